/* File: sim/radc_cfg_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker for the config bank
// ****************************************
module radc_cfg_sva
    import radc_pkg::*;
#(
    parameter int MOD_W = 24
) (
    input wire logic             core_clk,       // Clock
    input wire logic             reset,          // Async reset
    input wire logic             reg_wr_en,      // Write strobe
    input wire logic             reg_rd_en,      // Read strobe
    input wire logic [7:0]       reg_addr,       // Offset
    input wire logic [7:0]       reg_wr_data,    // Write data
    input wire logic [7:0]       reg_rd_data,    // Read data
    input wire logic             fs_tick,        // Sample pulse
    input wire logic             clock_error,    // Emergency cause
    input wire logic             power_outage,   // Emergency cause
    input wire logic             zero_left,      // Left zero met
    input wire logic             zero_right,     // Right zero met
    input wire logic [7:0]       volume_atten,   // Attenuation
    input wire logic             emerg_active,   // Emergency state
    input wire logic             mute_left,      // Left muted
    input wire logic             mute_right,     // Right muted
    input wire logic [1:0]       left_ac_gain,   // Field
    input wire logic [1:0]       right_ac_gain,  // Field
    input wire logic [1:0]       left_dem_gain,  // Field
    input wire logic [1:0]       right_dem_gain, // Field
    input wire logic [MOD_W-1:0] left_dc_offset  // DC add
);
    logic [7:0]  em_q, am_q, di_q, dh_q, dl_q, exp_rd;
    logic [10:0] dc_amt;
    logic        ql, qr, exp_l, exp_r;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    function automatic logic [7:0] sat(input logic [7:0] v,
                                       input logic [1:0] s);
        logic [8:0] t;
        t = {1'b0, v} + (9'h008 >> s);
        return t[8] ? 8'hFF : t[7:0];
    endfunction
    // Shadow of the bank, kept from the write strobes only
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            em_q <= 8'h10;
            am_q <= 8'h07;
            di_q <= 8'h00;
            dh_q <= 8'h00;
            dl_q <= 8'h00;
        end else if (reg_wr_en) begin
            case (reg_addr)
                8'h40: em_q <= reg_wr_data;
                8'h41: am_q <= reg_wr_data;
                8'h43: di_q <= reg_wr_data;
                8'h44: dh_q <= reg_wr_data;
                8'h45: dl_q <= reg_wr_data;
                default: ;
            endcase
        end
    end
    // Expected read word and mute levels
    always_comb begin
        case (reg_addr)
            8'h40: exp_rd = em_q;
            8'h41: exp_rd = am_q;
            8'h43: exp_rd = di_q;
            8'h44: exp_rd = dh_q;
            8'h45: exp_rd = dl_q;
            default: exp_rd = 8'h00;
        endcase
    end
    assign dc_amt = {dh_q[2:0], dl_q};
    assign ql     = zero_left & am_q[0];
    assign qr     = zero_right & am_q[1];
    // Coupled mode waits for both sides to qualify
    assign exp_l  = am_q[2] ? (ql & qr) : ql;
    assign exp_r  = am_q[2] ? (ql & qr) : qr;
    sequence s_emerg_tick;
        emerg_active && fs_tick && (clock_error || power_outage)
            && em_q[7:6] == 2'h0;
    endsequence
    a_read_data: assert property (reg_rd_en |=>
        reg_rd_data == $past(exp_rd)) else $error("read word wrong");
    a_read_hold: assert property (!reg_rd_en |=> $stable(reg_rd_data))
        else $error("read data moved without a read");
    a_mute_left: assert property (mute_left == $past(exp_l))
        else $error("left auto-mute wrong");
    a_mute_right: assert property (mute_right == $past(exp_r))
        else $error("right auto-mute wrong");
    a_ac_gains: assert property ({left_ac_gain, right_ac_gain} ==
        di_q[7:4]) else $error("AC gain fields wrong");
    a_dem_gains: assert property ({left_dem_gain, right_dem_gain} ==
        di_q[3:0]) else $error("DEM gain fields wrong");
    a_dc_offset: assert property (dc_amt == $past(dc_amt) &&
        dc_amt == $past(dc_amt, 2) |->
        left_dc_offset == (MOD_W'(dc_amt) << 8))
        else $error("DC dither offset wrong");
    a_emerg_enter: assert property ($rose(clock_error || power_outage)
        |=> emerg_active) else $error("emergency not entered");
    a_emerg_step: assert property (s_emerg_tick |=>
        volume_atten == sat($past(volume_atten), $past(em_q[5:4])))
        else $error("emergency step wrong");
    a_instant_mute: assert property (emerg_active && em_q[7:6] == 2'h3
        && (clock_error || power_outage) |-> ##[1:2] volume_atten == 8'hFF)
        else $error("instant mute missing");
endmodule // radc_cfg_sva
bind radc_cfg radc_cfg_sva #(.MOD_W(MOD_W)) u_sva (.*);
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import radc_pkg::*;
    logic core_clk, reset, reg_wr_en, reg_rd_en, fs_tick, soft_mute_pin;
    logic soft_mute_reg, clock_error, power_outage, zero_left, zero_right;
    logic emerg_active, mute_left, mute_right, ql, qr;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data, volume_atten, v0;
    logic [1:0] normal_rate, normal_step, left_ac_gain, right_ac_gain;
    logic [1:0] left_dem_gain, right_dem_gain;
    logic [23:0] left_dc_offset;
    logic [7:0] ofs[6] = '{8'h40, 8'h41, 8'h43, 8'h44, 8'h45, 8'h42};
    logic [7:0] rst[6] = '{8'h10, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] rexp[4] = '{8'h20, 8'h10, 8'h08, 8'hFF};
    int failures, tests_run, cycles;
    radc_cfg #(.MOD_W(24)) u_dut (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard; the whole run takes about 400 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            $display("Error at %0t: run hung", $time);
            wrap_up();
        end
    end
    task automatic check(input logic [23:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    // Every task starts and ends 1 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, d);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        step(1);
        reg_wr_en = 1'b0;
        step(1); // Idle edge so a next write never re-raises at once
    endtask
    task automatic rd(input logic [7:0] a, exp);
        reg_rd_en = 1'b1;
        reg_addr = a;
        step(1);
        reg_rd_en = 1'b0;
        step(1);
        check({16'h0, reg_rd_data}, {16'h0, exp});
    endtask
    task automatic tick;
        fs_tick = 1'b1;
        step(1);
        fs_tick = 1'b0;
        step(2);
    endtask
    task automatic do_reset;
        reset = 1'b1;
        step(3);
        reset = 1'b0;
    endtask
    // Emergency run from unity; low cfg bit picks the cause
    task automatic emerg(input logic [7:0] cfg, input int n,
                         input logic [7:0] exp);
        do_reset();
        wr(8'h40, cfg);
        clock_error = ~cfg[0];
        power_outage = cfg[0];
        step(2);
        check({23'h0, emerg_active}, 24'h1);
        repeat (n) tick();
        check({16'h0, volume_atten}, {16'h0, exp});
        clock_error = 1'b0;
        power_outage = 1'b0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {reset, reg_wr_en, reg_rd_en, fs_tick, soft_mute_pin} = 5'h10;
        {soft_mute_reg, clock_error, power_outage} = 3'h0;
        {zero_left, zero_right, normal_rate, normal_step} = 6'h00;
        {reg_addr, reg_wr_data} = 16'h0000;
        step(3);
        reset = 1'b0;
        for (int i = 0; i < 6; i++)
            rd(ofs[i], rst[i]);
        wr(8'h44, 8'hFD);
        wr(8'h45, 8'h5A);
        step(3);
        check(left_dc_offset, 24'h055A00);
        rd(8'h44, 8'hFD);
        wr(8'h44, 8'h00);
        wr(8'h45, 8'h00);
        step(3);
        check(left_dc_offset, 24'h000000);
        // Only the two legal DEM codes are ever written
        for (int k = 0; k < 2; k++) begin
            v0 = {1'b0, k[0], 1'b0, ~k[0], 1'b0, k[0], 1'b0, ~k[0]};
            wr(8'h43, v0);
            check({left_ac_gain, right_ac_gain,
                   left_dem_gain, right_dem_gain}, {16'h0, v0});
        end
        for (int c = 0; c < 32; c++) begin
            wr(8'h41, {5'h15, c[4:2]});
            zero_left = c[0];
            zero_right = c[1];
            step(2);
            ql = c[0] & c[2];
            qr = c[1] & c[3];
            check({mute_left, mute_right},
                  c[4] ? {2{ql & qr}} : {ql, qr});
        end
        {zero_left, zero_right} = 2'b00;
        for (int i = 0; i < 4; i++)
            emerg({2'h0, i[1:0], 3'h0, i[0]}, 2, 8'h10 >> i);
        for (int j = 0; j < 4; j++)
            emerg({j[1:0], 2'h1, 4'hA}, 8, rexp[j]);
        // Soft mute by register then pin, then an emergency mid-ramp
        for (int p = 0; p < 2; p++) begin
            do_reset();
            wr(8'h40, 8'h00);
            {normal_rate, normal_step} = 4'h7; // Every 2nd sample, 0.5 dB
            soft_mute_pin = p[0];
            soft_mute_reg = ~p[0];
            step(4);
            tick();
            v0 = volume_atten;
            tick();
            check({16'h0, volume_atten}, {16'h0, v0 + 8'h01});
            clock_error = 1'b1;
            step(2);
            v0 = volume_atten;
            tick();
            check({16'h0, volume_atten}, {16'h0, v0 + 8'h08});
            {clock_error, soft_mute_pin, soft_mute_reg} = 3'h0;
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

/* File: verilog/radc_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
module radc_cfg
    import radc_pkg::*;
#(
    parameter int MOD_W = 24
) (
    input  wire logic             core_clk,        // 200 MHz clock
    input  wire logic             reset,           // Async, active high
    input  wire logic             reg_wr_en,       // Register write strobe
    input  wire logic             reg_rd_en,       // Register read strobe
    input  wire logic [7:0]       reg_addr,        // Register offset
    input  wire logic [7:0]       reg_wr_data,     // Write data
    output logic      [7:0]       reg_rd_data,     // Read data
    input  wire logic             fs_tick,         // One pulse per sample
    input  wire logic             soft_mute_pin,   // Soft mute pin, async
    input  wire logic             soft_mute_reg,   // Soft mute register bit
    input  wire logic [1:0]       normal_rate,     // Normal ramp rate
    input  wire logic [1:0]       normal_step,     // Normal ramp step
    input  wire logic             clock_error,     // Clock error event
    input  wire logic             power_outage,    // Power outage event
    input  wire logic             zero_left,       // Left zero time met
    input  wire logic             zero_right,      // Right zero time met
    output logic      [7:0]       volume_atten,    // 0.5 dB units, FF mute
    output logic                  emerg_active,    // Emergency ramp running
    output logic                  mute_left,       // Left auto-muted
    output logic                  mute_right,      // Right auto-muted
    output logic      [1:0]       left_ac_gain,    // Left AC dither code
    output logic      [1:0]       right_ac_gain,   // Right AC dither code
    output logic      [1:0]       left_dem_gain,   // Left DEM dither code
    output logic      [1:0]       right_dem_gain,  // Right DEM dither code
    output logic      [MOD_W-1:0] left_dc_offset   // Left DC dither add
);

    // ****************************************
    // Register file
    // ****************************************
    logic [7:0] emerg_q, emerg_d;
    logic [7:0] amute_q, amute_d;
    logic [7:0] dith_q, dith_d;
    logic [7:0] dchi_q, dchi_d;
    logic [7:0] dclo_q, dclo_d;
    logic [7:0] rd_q, rd_d;

    // Writes land whole, reserved bits kept as storage
    always_comb begin
        emerg_d = emerg_q;
        amute_d = amute_q;
        dith_d  = dith_q;
        dchi_d  = dchi_q;
        dclo_d  = dclo_q;
        if (reg_wr_en) begin
            case (reg_addr)
                EMERG_RAMP_OFS: emerg_d = reg_wr_data;
                AUTOMUTE_OFS:   amute_d = reg_wr_data;
                DITHER_OFS:     dith_d  = reg_wr_data;
                DC_HI_OFS:      dchi_d  = reg_wr_data;
                DC_LO_OFS:      dclo_d  = reg_wr_data;
                default:        emerg_d = emerg_q;
            endcase
        end
    end

    // Read mux; unmapped offsets return zero
    always_comb begin
        rd_d = rd_q;
        if (reg_rd_en) begin
            case (reg_addr)
                EMERG_RAMP_OFS: rd_d = emerg_q;
                AUTOMUTE_OFS:   rd_d = amute_q;
                DITHER_OFS:     rd_d = dith_q;
                DC_HI_OFS:      rd_d = dchi_q;
                DC_LO_OFS:      rd_d = dclo_q;
                default:        rd_d = 8'h00;
            endcase
        end
    end

    // Register storage
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            emerg_q <= EMERG_RAMP_RST;
            amute_q <= AUTOMUTE_RST;
            dith_q  <= DITHER_RST;
            dchi_q  <= DC_HI_RST;
            dclo_q  <= DC_LO_RST;
            rd_q    <= 8'h00;
        end else begin
            emerg_q <= emerg_d;
            amute_q <= amute_d;
            dith_q  <= dith_d;
            dchi_q  <= dchi_d;
            dclo_q  <= dclo_d;
            rd_q    <= rd_d;
        end
    end

    assign reg_rd_data = rd_q;

    // ****************************************
    // Field decode
    // ****************************************
    logic [1:0] emerg_ramp_rate;
    logic [1:0] emerg_ramp_step;
    logic       automute_coupling;
    logic       automute_en_a;
    logic       automute_en_b;

    assign emerg_ramp_rate   = emerg_q[RATE_LSB +: 2];
    assign emerg_ramp_step   = emerg_q[STEP_LSB +: 2];
    assign automute_coupling = amute_q[COUPLING_BIT];
    assign automute_en_a     = amute_q[EN_A_BIT];
    assign automute_en_b     = amute_q[EN_B_BIT];

    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic sm_meta_q, sm_sync_q;

    // Second flop only is read by the ramp logic
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sm_meta_q <= 1'b0;
            sm_sync_q <= 1'b0;
        end else begin
            sm_meta_q <= soft_mute_pin;
            sm_sync_q <= sm_meta_q;
        end
    end

    // ****************************************
    // Volume ramp engine
    // ****************************************
    radc_state_type state_q, state_d;
    logic [7:0] vol_q, vol_d;
    logic [1:0] div_q, div_d;
    logic       emerg_req;
    logic       soft_req;
    logic [1:0] sel_rate;
    logic [1:0] sel_step;
    logic [7:0] step_amt;
    logic       upd;

    // Emergency only from clock fault or outage
    assign emerg_req = clock_error | power_outage;
    assign soft_req  = sm_sync_q | soft_mute_reg;

    // Decrement size in half-dB units
    function automatic logic [7:0] step_of(input logic [1:0] c);
        case (c)
            2'h0:    step_of = STEP_4DB;
            2'h1:    step_of = STEP_2DB;
            2'h2:    step_of = STEP_1DB;
            default: step_of = STEP_HALFDB;
        endcase
    endfunction

    // Sample-rate divider gates each update
    function automatic logic due(input logic [1:0] r,
                                 input logic [1:0] cnt);
        case (r)
            RATE_EVERY1: due = 1'b1;
            RATE_EVERY2: due = cnt[0];
            RATE_EVERY4: due = (cnt == 2'h3);
            default:     due = 1'b1;
        endcase
    endfunction

    // Next state, ramp settings and volume
    always_comb begin
        state_d  = state_q;
        vol_d    = vol_q;
        div_d    = div_q;
        sel_rate = normal_rate;
        sel_step = normal_step;
        case (state_q)
            RADC_IDLE: begin
                if (emerg_req) begin
                    state_d = RADC_EMERG;
                end else if (soft_req && vol_q != VOL_MUTE) begin
                    state_d = RADC_NORMAL;
                end else if (!soft_req && vol_q != VOL_UNITY) begin
                    state_d = RADC_NORMAL;
                end
            end
            RADC_NORMAL: begin
                if (emerg_req) begin
                    state_d = RADC_EMERG;
                end
            end
            RADC_EMERG: begin
                sel_rate = emerg_ramp_rate;
                sel_step = emerg_ramp_step;
                if (!emerg_req) begin
                    state_d = RADC_NORMAL;
                end
            end
            default: state_d = RADC_IDLE;
        endcase
        step_amt = step_of(sel_step);
        upd      = fs_tick && due(sel_rate, div_q);
        if (fs_tick) begin
            div_d = div_q + 2'h1;
        end
        if (state_q == RADC_EMERG || soft_req) begin
            // Ramp down from wherever the volume stands
            if (sel_rate == RATE_INSTANT) begin
                vol_d = VOL_MUTE;
            end else if (upd) begin
                if (vol_q > VOL_MUTE - step_amt) begin
                    vol_d = VOL_MUTE;
                end else begin
                    vol_d = vol_q + step_amt;
                end
            end
        end else if (state_q == RADC_NORMAL) begin
            // Unmute mirrors the normal settings
            if (sel_rate == RATE_INSTANT) begin
                vol_d = VOL_UNITY;
            end else if (upd) begin
                if (vol_q < step_amt) begin
                    vol_d = VOL_UNITY;
                end else begin
                    vol_d = vol_q - step_amt;
                end
            end
        end
        if (state_q == RADC_NORMAL && !emerg_req) begin
            if (soft_req && vol_d == VOL_MUTE) begin
                state_d = RADC_IDLE;
            end else if (!soft_req && vol_d == VOL_UNITY) begin
                state_d = RADC_IDLE;
            end
        end
    end

    // Ramp state registers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q <= RADC_IDLE;
            vol_q   <= VOL_UNITY;
            div_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            vol_q   <= vol_d;
            div_q   <= div_d;
        end
    end

    assign volume_atten = vol_q;
    assign emerg_active = (state_q == RADC_EMERG);

    // ****************************************
    // Auto-mute
    // ****************************************
    logic qual_l, qual_r;
    logic am_l_q, am_l_d;
    logic am_r_q, am_r_d;

    // Zero flags arrive already timed elsewhere
    assign qual_l = zero_left  & automute_en_b;
    assign qual_r = zero_right & automute_en_a;

    // Coupled mode needs both channels to qualify
    always_comb begin
        if (automute_coupling) begin
            am_l_d = qual_l & qual_r;
            am_r_d = qual_l & qual_r;
        end else begin
            am_l_d = qual_l;
            am_r_d = qual_r;
        end
    end

    // Auto-mute outputs
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            am_l_q <= 1'b0;
            am_r_q <= 1'b0;
        end else begin
            am_l_q <= am_l_d;
            am_r_q <= am_r_d;
        end
    end

    assign mute_left  = am_l_q;
    assign mute_right = am_r_q;

    // ****************************************
    // Dither settings
    // ****************************************
    logic [DC_W-1:0]  dc_amount;
    logic [MOD_W-1:0] dc_off_q, dc_off_d;

    // Gain codes pass straight from storage
    assign left_ac_gain   = dith_q[L_AC_LSB +: 2];
    assign right_ac_gain  = dith_q[R_AC_LSB +: 2];
    assign left_dem_gain  = dith_q[L_DEM_LSB +: 2];
    assign right_dem_gain = dith_q[R_DEM_LSB +: 2];

    // Upper three bits from the first register
    assign dc_amount = {dchi_q[DC_HI_W-1:0], dclo_q};

    // Q0.11 amount, 1.0 lands at 1/32 full scale
    always_comb begin
        dc_off_d = '0;
        dc_off_d[MOD_W-1-DC_SCALE_SHIFT -: DC_W] = dc_amount;
    end

    // Registered so the modulator sees a clean word
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dc_off_q <= '0;
        end else begin
            dc_off_q <= dc_off_d;
        end
    end

    assign left_dc_offset = dc_off_q;

endmodule // radc_cfg
`default_nettype wire

/* File: verilog/radc_pkg.sv */
`default_nettype none
package radc_pkg;
    // ****************************************
    // Register offsets on the control port
    // ****************************************
    localparam logic [7:0] EMERG_RAMP_OFS = 8'h40;
    localparam logic [7:0] AUTOMUTE_OFS   = 8'h41;
    localparam logic [7:0] DITHER_OFS     = 8'h43;
    localparam logic [7:0] DC_HI_OFS      = 8'h44;
    localparam logic [7:0] DC_LO_OFS      = 8'h45;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] EMERG_RAMP_RST = 8'h10;
    localparam logic [7:0] AUTOMUTE_RST   = 8'h07;
    localparam logic [7:0] DITHER_RST     = 8'h00;
    localparam logic [7:0] DC_HI_RST      = 8'h00;
    localparam logic [7:0] DC_LO_RST      = 8'h00;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int RATE_LSB     = 6;
    localparam int STEP_LSB     = 4;
    localparam int COUPLING_BIT = 2;
    localparam int EN_A_BIT     = 1;
    localparam int EN_B_BIT     = 0;
    localparam int L_AC_LSB     = 6;
    localparam int R_AC_LSB     = 4;
    localparam int L_DEM_LSB    = 2;
    localparam int R_DEM_LSB    = 0;
    localparam int DC_HI_W      = 3;
    localparam int DC_W         = 11;
    // ****************************************
    // Ramp encodings, volume in 0.5 dB units
    // ****************************************
    localparam logic [1:0] RATE_EVERY1  = 2'h0;
    localparam logic [1:0] RATE_EVERY2  = 2'h1;
    localparam logic [1:0] RATE_EVERY4  = 2'h2;
    localparam logic [1:0] RATE_INSTANT = 2'h3;
    localparam logic [7:0] STEP_4DB     = 8'h08;
    localparam logic [7:0] STEP_2DB     = 8'h04;
    localparam logic [7:0] STEP_1DB     = 8'h02;
    localparam logic [7:0] STEP_HALFDB  = 8'h01;
    localparam logic [7:0] VOL_UNITY    = 8'h00;
    localparam logic [7:0] VOL_MUTE     = 8'hFF;
    // DC dither 1.0 equals 1/32 of full scale
    localparam int DC_SCALE_SHIFT = 5;
    typedef enum logic [1:0] {
        RADC_IDLE   = 2'b00,
        RADC_NORMAL = 2'b01,
        RADC_EMERG  = 2'b10
    } radc_state_type;
endpackage
`default_nettype wire
